// [hw/pci_local_window_decode.sv]
/*
 * inbound pci window decode: expansion rom and space 0 windows with
 * remap, region descriptor and delayed local bus request.
 * assumes pci address strobe and hold inputs come from logic on aclk;
 * hold_grant_in is a pin and is synchronised here.
 */
// Function
// RL1: rom window active straight after reset
// RL2: software disables rom via 30h and 94h
// RL3: rom range bits 31:11 mask decode
// RL4: rom range resets to 64 kbyte window
// RL5: rom hit remaps upper bits from 94h
// RL6: software sizes rom range register correctly
// RL7: request after programmed delay, eight clocks step
// RL8: request held until hold grant arrives
// RL9: request only when enable bit four set
// RL10: platform programs enable and delay seven
// RL11: software programs rom region descriptor values
// RL12: space0 range bit0 selects memory space
// RL13: space0 bits 1-3 read as programmed
// RL14: space0 hit remaps upper bits from 84h
// RL15: space0 local base bit0 enables window
// RL16: rom local base bits 10:5 read zero
// RL17: hit needs enable and masked base match
// RL18: descriptor width 00 8, 01 16, else 32
`timescale 1ns/10ps
`default_nettype none
module pci_local_window_decode
	import win_decode_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        clk_en,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        pci_valid,
	input  wire logic [31:0] pci_addr,
	input  wire logic        pci_is_io,
	input  wire logic [31:0] pci_space0_base,
	output logic             rom_hit,
	output logic             space0_hit,
	output logic [31:0]      local_addr,
	output logic [1:0]       local_bus_width,
	input  wire logic        slave_hold_pending,
	input  wire logic        master_in_progress,
	input  wire logic        hold_grant_in,
	output logic             local_bus_request_out
);
	logic [31:0] pci_rom_base_config_reg;
	logic [31:0] space0_range_mask_reg;
	logic [31:0] space0_local_base_reg;
	logic [31:0] rom_range_mask_reg;
	logic [31:0] rom_local_base_and_request_reg;
	logic [31:0] inbound_region_descriptor_reg;
	logic        aw_held_reg;
	logic [7:0]  aw_addr_reg;
	logic        w_held_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        grant_meta_reg;
	logic        grant_sync_reg;
	logic [6:0]  delay_cnt_reg;
	logic [6:0]  delay_cnt_next;
	logic        wr_fire;
	logic        rd_fire;
	logic [31:0] rom_mask_eff;
	logic [31:0] space0_mask_eff;

	typedef enum logic [2:0] {
		req_idle  = 3'b001,
		req_count = 3'b010,
		req_high  = 3'b100
	} req_state_t;
	req_state_t req_state_reg;

	// byte-lane merge of a write into a register, keeping fixed bits
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb,
		input logic [31:0] wmask);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return (res & wmask) | (old & ~wmask);
	endfunction

	// width decode: 10 and 11 both mean a 32-bit bus
	function automatic logic [1:0] width_of(input logic [1:0] code);
		return (code[1]) ? bw_32 : code; // RL18
	endfunction

	// write address and data taken independently, in either order
	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;

	// write channel capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_held_reg  <= 1'b0;
			w_data_reg  <= 32'h00000000;
			w_strb_reg  <= 4'h0;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held_reg <= 1'b0;
			end
		end
	end

	// write response; unmapped or read-only address answers slverr
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= resp_okay;
		end else if (clk_en) begin
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				unique case (aw_addr_reg & 8'hfc)
					off_pci_rom_base_config, off_space0_range_mask,
					off_space0_local_base, off_rom_range_mask,
					off_rom_local_base_and_request,
					off_inbound_region_descriptor: s_axi_bresp <= resp_okay;
					default: s_axi_bresp <= resp_slverr;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// register file; rom window and range come up live from reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pci_rom_base_config_reg        <= rst_pci_rom_base; // RL1
			space0_range_mask_reg          <= rst_zero; // RL12 RL13
			space0_local_base_reg          <= rst_zero;
			rom_range_mask_reg             <= rst_rom_range_mask; // RL4
			rom_local_base_and_request_reg <= rst_rom_local_base; // RL9
			inbound_region_descriptor_reg  <= rst_zero;
		end else if (clk_en && wr_fire) begin
			unique case (aw_addr_reg & 8'hfc)
				off_pci_rom_base_config: pci_rom_base_config_reg <=
					merge(pci_rom_base_config_reg, w_data_reg,
						w_strb_reg, 32'hfffff801);
				off_space0_range_mask: space0_range_mask_reg <=
					merge(space0_range_mask_reg, w_data_reg,
						w_strb_reg, 32'hffffffff);
				off_space0_local_base: space0_local_base_reg <=
					merge(space0_local_base_reg, w_data_reg,
						w_strb_reg, 32'hffffffff);
				off_rom_range_mask: rom_range_mask_reg <=
					merge(rom_range_mask_reg, w_data_reg,
						w_strb_reg, rom_range_wmask); // RL3
				off_rom_local_base_and_request:
					rom_local_base_and_request_reg <=
					merge(rom_local_base_and_request_reg, w_data_reg,
						w_strb_reg, rom_local_wmask); // RL16
				off_inbound_region_descriptor:
					inbound_region_descriptor_reg <=
					merge(inbound_region_descriptor_reg, w_data_reg,
						w_strb_reg, 32'hffffffff);
				default: ;
			endcase
		end
	end

	// read data registered; unmapped reads give zero and slverr
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= resp_okay;
		end else if (clk_en) begin
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= resp_okay;
				unique case (s_axi_araddr & 8'hfc)
					off_pci_rom_base_config:
						s_axi_rdata <= pci_rom_base_config_reg;
					off_space0_range_mask:
						s_axi_rdata <= space0_range_mask_reg;
					off_space0_local_base:
						s_axi_rdata <= space0_local_base_reg;
					off_rom_range_mask:
						s_axi_rdata <= rom_range_mask_reg;
					off_rom_local_base_and_request:
						s_axi_rdata <= rom_local_base_and_request_reg;
					off_inbound_region_descriptor:
						s_axi_rdata <= inbound_region_descriptor_reg;
					off_status:
						s_axi_rdata <= {29'h0, grant_sync_reg,
							local_bus_request_out,
							req_state_reg == req_count};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= resp_slverr;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// two decode windows share one matcher module each
	win_match_if rom_if ();
	win_match_if sp0_if ();
	assign rom_mask_eff    = rom_range_mask_reg & rom_range_wmask; // RL3
	assign space0_mask_eff = space0_range_mask_reg & space0_range_wmask;
	assign rom_if.pci_addr = pci_addr;
	assign rom_if.pci_base = pci_rom_base_config_reg;
	assign rom_if.mask     = rom_mask_eff;
	assign rom_if.remap    = rom_local_base_and_request_reg; // RL5
	assign rom_if.enable   = pci_rom_base_config_reg[rom_en_bit] && !pci_is_io;
	assign sp0_if.pci_addr = pci_addr;
	assign sp0_if.pci_base = pci_space0_base;
	assign sp0_if.mask     = space0_mask_eff;
	assign sp0_if.remap    = space0_local_base_reg; // RL14
	// window type from bit 0: memory when clear, io when set
	assign sp0_if.enable   = space0_local_base_reg[space0_en_bit] &&
		(space0_range_mask_reg[space0_io_bit] == pci_is_io); // RL12 RL15
	win_match u_rom (.m(rom_if.match));
	win_match u_sp0 (.m(sp0_if.match));

	// registered decode result, rom takes priority on overlap
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rom_hit         <= 1'b0;
			space0_hit      <= 1'b0;
			local_addr      <= 32'h00000000;
			local_bus_width <= bw_8;
		end else if (clk_en) begin
			rom_hit    <= pci_valid && rom_if.hit;
			space0_hit <= pci_valid && sp0_if.hit && !rom_if.hit;
			if (pci_valid && rom_if.hit) begin
				local_addr <= rom_if.local_addr;
			end else if (pci_valid && sp0_if.hit) begin
				local_addr <= sp0_if.local_addr;
			end
			local_bus_width <= width_of(
				inbound_region_descriptor_reg[width_lsb +: 2]); // RL18
		end
	end

	// hold grant pin synchroniser
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			grant_meta_reg <= 1'b0;
			grant_sync_reg <= 1'b0;
		end else if (clk_en) begin
			grant_meta_reg <= hold_grant_in;
			grant_sync_reg <= grant_meta_reg;
		end
	end

	// delay target: code times eight clocks
	assign delay_cnt_next = 7'(rom_local_base_and_request_reg[
		breq_dly_lsb +: breq_dly_w]) * step_clocks; // RL7

	// bus request sequencer; deadlock case counted then held to grant
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			req_state_reg         <= req_idle;
			delay_cnt_reg         <= 7'h00;
			local_bus_request_out <= 1'b0;
		end else if (clk_en) begin
			unique case (req_state_reg)
				req_idle: begin
					delay_cnt_reg <= 7'h00;
					if (slave_hold_pending && master_in_progress &&
						!grant_sync_reg &&
						rom_local_base_and_request_reg[breq_en_bit]) begin
						req_state_reg <= req_count; // RL7 RL9
					end
				end
				req_count: begin
					if (!(slave_hold_pending && master_in_progress) ||
						grant_sync_reg ||
						!rom_local_base_and_request_reg[breq_en_bit]) begin
						req_state_reg <= req_idle;
					end else if (delay_cnt_reg + 7'h01 >= delay_cnt_next) begin
						req_state_reg         <= req_high; // RL7
						local_bus_request_out <= 1'b1;
					end else begin
						delay_cnt_reg <= delay_cnt_reg + 7'h01;
					end
				end
				req_high: begin
					if (grant_sync_reg) begin
						req_state_reg         <= req_idle; // RL8
						local_bus_request_out <= 1'b0;
					end
				end
			endcase
		end
	end

	// checks
	property p_req_needs_enable;
		@(posedge aclk) disable iff (!aresetn)
		$rose(local_bus_request_out) |->
			$past(rom_local_base_and_request_reg[breq_en_bit]);
	endproperty
	a_req_needs_enable: assert property (p_req_needs_enable) // RL9
		else $error("bus request raised while disabled");

	property p_req_held;
		@(posedge aclk) disable iff (!aresetn)
		(local_bus_request_out && !grant_sync_reg) |=>
			local_bus_request_out;
	endproperty
	a_req_held: assert property (p_req_held) // RL8
		else $error("bus request dropped before grant");

	property p_rom_reset;
		@(posedge aclk) $rose(aresetn) |->
			rom_range_mask_reg == 32'hffff0000 &&
			pci_rom_base_config_reg[rom_en_bit];
	endproperty
	a_rom_reset: assert property (p_rom_reset) // RL1
		else $error("rom window not live after reset");

	// unknown before the first reset edge, so held off until then
	property p_unused_zero;
		@(posedge aclk) disable iff (!aresetn)
		rom_local_base_and_request_reg[10:5] == 6'h00;
	endproperty
	a_unused_zero: assert property (p_unused_zero) // RL16
		else $error("unused rom base bits nonzero");

	property p_range_low_zero;
		@(posedge aclk) rom_mask_eff[10:0] == 11'h000;
	endproperty
	a_range_low_zero: assert property (p_range_low_zero) // RL3
		else $error("rom decode uses offset bits");

	property p_rom_remap;
		@(posedge aclk) disable iff (!aresetn)
		(clk_en && pci_valid && rom_if.hit) |=>
			rom_hit && local_addr[10:0] == $past(pci_addr[10:0]);
	endproperty
	a_rom_remap: assert property (p_rom_remap) // RL5
		else $error("rom remap offset lost");

	property p_sp0_needs_enable;
		@(posedge aclk) disable iff (!aresetn)
		space0_hit |-> $past(space0_local_base_reg[space0_en_bit]);
	endproperty
	a_sp0_needs_enable: assert property (p_sp0_needs_enable) // RL15
		else $error("space0 hit while disabled");

	property p_width;
		@(posedge aclk) disable iff (!aresetn)
		clk_en && inbound_region_descriptor_reg[1] |=>
			local_bus_width == bw_32;
	endproperty
	a_width: assert property (p_width) // RL18
		else $error("bus width decode wrong");

	c_req: cover property (@(posedge aclk) $rose(local_bus_request_out));
	c_rom: cover property (@(posedge aclk) rom_hit);
	c_sp0: cover property (@(posedge aclk) space0_hit);
	c_wr: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
endmodule
`default_nettype wire

// [hw/win_decode_pkg.sv]
/*
 * constants for the inbound pci window decode block: register byte
 * offsets, field positions, reset values and timing counts.
 * assumes a 10 mhz local clock and a 32-bit axi4-lite register port.
 */
package win_decode_pkg;
	// register byte offsets
	localparam logic [7:0] off_pci_rom_base_config        = 8'h30;
	localparam logic [7:0] off_space0_range_mask          = 8'h80;
	localparam logic [7:0] off_space0_local_base          = 8'h84;
	localparam logic [7:0] off_rom_range_mask             = 8'h90;
	localparam logic [7:0] off_rom_local_base_and_request = 8'h94;
	localparam logic [7:0] off_inbound_region_descriptor  = 8'h98;
	localparam logic [7:0] off_status                     = 8'h9c;

	// reset values
	localparam logic [31:0] rst_rom_range_mask   = 32'hffff0000;
	localparam logic [31:0] rst_rom_local_base   = 32'hffff0000;
	localparam logic [31:0] rst_pci_rom_base     = 32'h00000001;
	localparam logic [31:0] rst_zero             = 32'h00000000;

	// writable bits, and the space0 range decode mask
	localparam logic [31:0] rom_range_wmask      = 32'hfffff800;
	localparam logic [31:0] rom_local_wmask      = 32'hfffff81f;
	localparam logic [31:0] space0_range_wmask   = 32'hfffffff0;

	// field positions
	localparam int rom_en_bit        = 0;
	localparam int space0_en_bit     = 0;
	localparam int space0_io_bit     = 0;
	localparam int breq_en_bit       = 4;
	localparam int breq_dly_lsb      = 0;
	localparam int breq_dly_w        = 4;
	localparam int rom_addr_lsb      = 11;
	localparam int width_lsb         = 0;

	// bus width codes
	localparam logic [1:0] bw_8  = 2'h0;
	localparam logic [1:0] bw_16 = 2'h1;
	localparam logic [1:0] bw_32 = 2'h2;

	// timing: one delay step is eight local clocks
	localparam int          clocks_per_step = 8;
	localparam logic [6:0]  step_clocks     = 7'(clocks_per_step);
	localparam int          clk_period_ns   = 100;

	// axi responses
	localparam logic [1:0] resp_okay   = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// [hw/win_match.sv]
/*
 * one decode window: masked compare of the pci address with the window
 * base and splice of the remap bits over the decoded bits.
 * assumes the mask already has only decode bits set.
 */
`timescale 1ns/10ps
`default_nettype none
module win_match
	import win_decode_pkg::*;
(
	win_match_if.match m
);
	// hit only when enabled and masked address equals masked base
	assign m.hit = m.enable &&
		((m.pci_addr & m.mask) == (m.pci_base & m.mask)); // RL17
	// decoded upper bits replaced, offset bits kept
	assign m.local_addr = (m.remap & m.mask) | (m.pci_addr & ~m.mask); // RL5 RL14
endmodule
`default_nettype wire

// [hw/win_match_if.sv]
/*
 * carries one window's base, mask and remap value into the matcher and
 * its hit and translated address back out.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface win_match_if;
	logic [31:0] pci_addr;
	logic [31:0] pci_base;
	logic [31:0] mask;
	logic [31:0] remap;
	logic        enable;
	logic        hit;
	logic [31:0] local_addr;
	modport ctrl (output pci_addr, pci_base, mask, remap, enable,
		input hit, local_addr);
	modport match (input pci_addr, pci_base, mask, remap, enable,
		output hit, local_addr);
endinterface
`default_nettype wire

// [verification/hold_arbiter_model.sv]
/*
 * far side model of the local processor bus: presents a pending slave
 * hold and a busy master access while start is high, then grants hold
 * a set number of clocks after the bus request shows.
 * assumes the bench's clock and synchronous active low reset.
 */
`timescale 1ns/10ps
`default_nettype none
module hold_arbiter_model (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       start,
	input  wire logic [7:0] grant_delay,
	input  wire logic       local_bus_request_out,
	output logic            slave_hold_pending,
	output logic            master_in_progress,
	output logic            hold_grant_in
);
	logic [7:0] wait_reg;

	// both deadlock conditions follow the bench's start level
	assign slave_hold_pending = start;
	assign master_in_progress = start;

	// grant late on purpose so the request must hold meanwhile
	always_ff @(posedge aclk) begin
		if (!aresetn || !local_bus_request_out) begin
			wait_reg      <= 8'h00;
			hold_grant_in <= 1'b0;
		end else if (wait_reg == grant_delay) begin
			hold_grant_in <= 1'b1;
		end else begin
			wait_reg <= wait_reg + 8'h01;
		end
	end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
/*
 * self-checking bench for the inbound window decode: register access
 * over axi4-lite, decode probes and delayed bus request timing.
 * assumes the hold arbiter model on the local side.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import win_decode_pkg::*;
;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready;
	logic        bvalid, bready, arvalid, arready, rvalid, rready;
	logic        pci_valid, pci_is_io, rom_hit, s0_hit, start;
	logic        hold_p, m_busy, grant, req, ce;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, bus_w;
	logic [7:0]  awaddr, araddr, gdly;
	logic [31:0] wdata, rdata, pci_addr, local_addr;
	logic [1:0]  wexp [4];
	int          error_cnt, cmp_count, cyc, i;

	pci_local_window_decode pci_local_window_decode_i (
		.aclk(aclk), .aresetn(aresetn), .clk_en(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.pci_valid(pci_valid), .pci_addr(pci_addr), .pci_is_io(pci_is_io),
		.pci_space0_base(32'h40000000), .rom_hit(rom_hit),
		.space0_hit(s0_hit), .local_addr(local_addr),
		.local_bus_width(bus_w), .slave_hold_pending(hold_p),
		.master_in_progress(m_busy), .hold_grant_in(grant),
		.local_bus_request_out(req));

	hold_arbiter_model hold_arbiter_model_i (
		.aclk(aclk), .aresetn(aresetn), .start(start),
		.grant_delay(gdly), .local_bus_request_out(req),
		.slave_hold_pending(hold_p), .master_in_progress(m_busy),
		.hold_grant_in(grant));

	// clock at 10 mhz
	always #50 aclk = ~aclk;

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// hang guard, well above the few hundred cycles the tests need
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			complete_run();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one write: address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		chk("bvalid", 32'h1, {31'h0, bvalid});
		chk("bresp", {30'h0, er}, {30'h0, bresp});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		chk("rvalid", 32'h1, {31'h0, rvalid});
		chk("rdata", e, rdata);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
	endtask

	// one-cycle address sample, hits read in the cycle they stand
	task automatic probe(input logic [31:0] a, input logic io,
		input logic er, input logic es, input logic [31:0] el);
		@(posedge aclk);
		pci_addr <= a;
		pci_is_io <= io;
		pci_valid <= 1'b1;
		@(posedge aclk);
		pci_valid <= 1'b0;
		@(posedge aclk);
		chk("rom_hit", {31'h0, er}, {31'h0, rom_hit});
		chk("space0_hit", {31'h0, es}, {31'h0, s0_hit});
		if (er | es) chk("local_addr", el, local_addr);
	endtask

	// delay to request, then request held until the late grant lands
	task automatic req_cycle(input int lo, input int hi, input int gd);
		int n;
		int m;
		@(posedge aclk);
		gdly <= 8'(gd);
		start <= 1'b1;
		for (n = 0; n < 200 && req !== 1'b1; n++) @(posedge aclk);
		for (m = 0; m < 200 && req === 1'b1; m++) @(posedge aclk);
		start <= 1'b0;
		chk("request_delay_in_range", 32'h1, {31'h0, n >= lo && n <= hi});
		chk("request_hold_in_range", 32'h1, {31'h0, m > gd && m < gd + 9});
	endtask

	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{pci_valid, pci_is_io, start} = 3'h0;
		ce = 1'b1;
		wstrb = 4'hf;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		pci_addr = 32'h0;
		gdly = 8'h00;
		wexp = '{bw_8, bw_16, bw_32, bw_32};
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		// reset values and an unmapped place
		rd(off_pci_rom_base_config, 32'h00000001, resp_okay);
		rd(off_space0_range_mask, 32'h0, resp_okay);
		rd(off_space0_local_base, 32'h0, resp_okay);
		rd(off_rom_range_mask, 32'hffff0000, resp_okay);
		rd(off_rom_local_base_and_request, 32'hffff0000, resp_okay);
		rd(off_inbound_region_descriptor, 32'h0, resp_okay);
		rd(8'h40, 32'h0, resp_slverr);
		wr(8'h44, 32'hffffffff, resp_slverr);
		// rom window live from reset with a 64 kbyte range
		probe(32'h00001234, 1'b0, 1'b1, 1'b0, 32'hffff1234);
		probe(32'h00001234, 1'b1, 1'b0, 1'b0, 32'h0);
		probe(32'h00010000, 1'b0, 1'b0, 1'b0, 32'h0);
		probe(32'h40000010, 1'b0, 1'b0, 1'b0, 32'h0);
		// clock enable low: a would-be rom hit must not show
		ce <= 1'b0;
		probe(32'h00001234, 1'b0, 1'b0, 1'b0, 32'h0);
		ce <= 1'b1;
		// space 0: 8 mbyte memory window remapped to a0000000
		wr(off_space0_range_mask, 32'hff800000, resp_okay);
		wr(off_space0_local_base, 32'ha0000001, resp_okay);
		rd(off_space0_range_mask, 32'hff800000, resp_okay);
		rd(off_space0_local_base, 32'ha0000001, resp_okay);
		probe(32'h407ffffc, 1'b0, 1'b0, 1'b1, 32'ha07ffffc);
		probe(32'h407ffffc, 1'b1, 1'b0, 1'b0, 32'h0);
		probe(32'h40800000, 1'b0, 1'b0, 1'b0, 32'h0);
		// rom resized to 512 kbyte and moved
		wr(off_rom_range_mask, 32'hffffffff, resp_okay);
		rd(off_rom_range_mask, 32'hfffff800, resp_okay);
		wr(off_rom_range_mask, 32'hfff80000, resp_okay);
		wr(off_rom_local_base_and_request, 32'hffffffff, resp_okay);
		rd(off_rom_local_base_and_request, 32'hfffff81f, resp_okay);
		wr(off_rom_local_base_and_request, 32'he0000017, resp_okay);
		wr(off_pci_rom_base_config, 32'h10000001, resp_okay);
		probe(32'h1007fff0, 1'b0, 1'b1, 1'b0, 32'he007fff0);
		probe(32'h10080000, 1'b0, 1'b0, 1'b0, 32'h0);
		// every width code, then the rom setting
		for (i = 0; i < 4; i++) begin
			wr(off_inbound_region_descriptor, 32'(i), resp_okay);
			repeat (2) @(posedge aclk);
			chk("bus_width", {30'h0, wexp[i]}, {30'h0, bus_w});
		end
		wr(off_inbound_region_descriptor, 32'h00000043, resp_okay);
		rd(off_inbound_region_descriptor, 32'h00000043, resp_okay);
		// only the low byte lane may land
		wstrb <= 4'h1;
		wr(off_inbound_region_descriptor, 32'hffffff43, resp_okay);
		rd(off_inbound_region_descriptor, 32'h00000043, resp_okay);
		wstrb <= 4'hf;
		// bus request: code 7, code 0, then disabled
		req_cycle(56, 62, 20);
		wr(off_rom_local_base_and_request, 32'he0000010, resp_okay);
		req_cycle(1, 5, 5);
		wr(off_rom_local_base_and_request, 32'he0000007, resp_okay);
		gdly <= 8'h00;
		start <= 1'b1;
		i = 0;
		repeat (100) begin
			@(posedge aclk);
			if (req !== 1'b0) i = 1;
		end
		// status is read only and shows neither counting nor request
		wr(off_status, 32'h00000007, resp_slverr);
		rd(off_status, 32'h0, resp_okay);
		start <= 1'b0;
		chk("request_while_disabled", 32'h0, 32'(i));
		// rom window switched off by software
		wr(off_pci_rom_base_config, 32'h0, resp_okay);
		wr(off_rom_local_base_and_request, 32'h0, resp_okay);
		probe(32'h00000000, 1'b0, 1'b0, 1'b0, 32'h0);
		complete_run();
	end
endmodule
`default_nettype wire
